// ===== rtl/tcp_buf2.sv
// two-entry valid/ready buffer for received write bytes
`timescale 1ns/10ps
module tcp_buf2 (
  input  wire logic       sys_clk,
  input  wire logic       nrst,
  input  wire logic       in_valid,
  output logic            in_ready,
  input  wire logic [7:0] in_addr,
  input  wire logic [7:0] in_data,
  output logic            out_valid,
  input  wire logic       out_ready,
  output logic      [7:0] out_addr,
  output logic      [7:0] out_data
);
  logic [15:0] mem_reg [0:tcp_pkg::BUF_DEPTH-1];
  logic        wp_reg;
  logic        rp_reg;
  logic [1:0]  cnt_reg;
  logic        push;
  logic        pop;

  // handshake terms
  assign in_ready  = (cnt_reg != 2'h2);
  assign out_valid = (cnt_reg != 2'h0);
  assign push      = in_valid & in_ready;
  assign pop       = out_valid & out_ready;
  assign out_addr  = mem_reg[rp_reg][15:8];
  assign out_data  = mem_reg[rp_reg][7:0];

  // storage write
  always_ff @(posedge sys_clk) begin
    if (push) begin
      mem_reg[wp_reg] <= {in_addr, in_data};
    end
  end

  // pointers and fill count
  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      wp_reg  <= 1'b0;
      rp_reg  <= 1'b0;
      cnt_reg <= 2'h0;
    end else begin
      if (push) wp_reg <= ~wp_reg;
      if (pop) rp_reg <= ~rp_reg;
      cnt_reg <= cnt_reg + {1'b0, push} - {1'b0, pop};
    end
  end
endmodule

// ===== rtl/tcp_pkg.sv
// constants for the two-wire slave register port
package tcp_pkg;
  localparam logic [6:0] DEV_ADDR       = 7'h68;
  localparam logic [7:0] CHG_CFG_OFFSET = 8'h10;
  localparam logic [7:0] CHG_CFG_RESET  = 8'h00;
  localparam logic [3:0] CHG_KEY        = 4'hA;
  localparam int         KEY_LSB        = 4;
  localparam int         DIODE_LSB      = 2;
  localparam int         RES_LSB        = 0;
  localparam logic [7:0] PTR_RESET      = 8'h00;
  localparam logic [3:0] BIT_LAST       = 4'h7;
  localparam logic [3:0] BIT_ACK        = 4'h8;
  localparam int         BUF_DEPTH      = 2;
  localparam int         MAP_WORDS      = 256;
  typedef enum logic [4:0] {
    TCP_IDLE = 5'b00001,
    TCP_ADDR = 5'b00010,
    TCP_PTR  = 5'b00100,
    TCP_WR   = 5'b01000,
    TCP_RD   = 5'b10000
  } tcp_state_t;
endpackage

// ===== rtl/tcp_slave.sv
// two-wire slave front end with register map and charge-path decode
`timescale 1ns/10ps
module tcp_slave (
  input  wire logic       sys_clk,
  input  wire logic       nrst,
  input  wire logic       scl_i,
  input  wire logic       sda_i,
  output logic            sda_o,
  output logic            sda_oe,
  output logic            charge_enable,
  output logic            charge_diode,
  output logic      [1:0] charge_res_sel,
  output logic      [7:0] charge_path_config,
  output logic            busy
);
  logic [7:0]  regmap_reg [0:tcp_pkg::MAP_WORDS-1];
  logic [7:0]  cfg_reg;
  logic [1:0]  scl_sync_reg;
  logic [1:0]  sda_sync_reg;
  logic        scl_d_reg;
  logic        sda_d_reg;
  logic        scl_rise;
  logic        scl_fall;
  logic        start_det;
  logic        stop_det;
  tcp_pkg::tcp_state_t state_reg;
  logic [3:0]  bit_reg;
  logic [7:0]  shift_reg;
  logic [7:0]  ptr_reg;
  logic [7:0]  tx_reg;
  logic        ack_reg;
  logic        drive_reg;
  logic        drv_val_reg;
  logic        master_nak_reg;
  logic        wq_valid;
  logic        wq_ready;
  logic [7:0]  wq_addr;
  logic [7:0]  wq_data;
  logic        wb_valid;
  logic [7:0]  wb_addr;
  logic [7:0]  wb_data;
  logic [7:0]  rd_data;
  logic [7:0]  rx_byte;
  logic [3:0]  key;
  logic [1:0]  dsel;
  logic [1:0]  rsel;

  // two-flop synchronisers for the bus pins
  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      scl_sync_reg <= 2'b11;
      sda_sync_reg <= 2'b11;
    end else begin
      scl_sync_reg <= {scl_sync_reg[0], scl_i};
      sda_sync_reg <= {sda_sync_reg[0], sda_i};
    end
  end

  // delayed copies for edge finding
  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      scl_d_reg <= 1'b1;
      sda_d_reg <= 1'b1;
    end else begin
      scl_d_reg <= scl_sync_reg[1];
      sda_d_reg <= sda_sync_reg[1];
    end
  end

  // edge and bus condition decode, oversampled far above 400kHz
  assign scl_rise  = scl_sync_reg[1] & ~scl_d_reg;
  assign scl_fall  = ~scl_sync_reg[1] & scl_d_reg;
  assign start_det = scl_sync_reg[1] & scl_d_reg &
                     sda_d_reg & ~sda_sync_reg[1];
  assign stop_det  = scl_sync_reg[1] & scl_d_reg &
                     ~sda_d_reg & sda_sync_reg[1];
  assign rx_byte   = {shift_reg[6:0], sda_sync_reg[1]};

  // read data from the map, config register kept apart
  assign rd_data = (ptr_reg == tcp_pkg::CHG_CFG_OFFSET) ? cfg_reg
                                                        : regmap_reg[ptr_reg];

  // protocol state machine
  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      state_reg      <= tcp_pkg::TCP_IDLE;
      bit_reg        <= 4'h0;
      shift_reg      <= 8'h00;
      ack_reg        <= 1'b0;
      master_nak_reg <= 1'b0;
    end else if (start_det) begin
      state_reg <= tcp_pkg::TCP_ADDR;
      bit_reg   <= 4'h0;
      ack_reg   <= 1'b0;
    end else if (stop_det) begin
      state_reg <= tcp_pkg::TCP_IDLE;
      bit_reg   <= 4'h0;
      ack_reg   <= 1'b0;
    end else if (scl_rise && state_reg != tcp_pkg::TCP_IDLE) begin
      if (bit_reg == tcp_pkg::BIT_ACK) begin
        bit_reg <= 4'h0;
        if (state_reg == tcp_pkg::TCP_RD) begin
          master_nak_reg <= sda_sync_reg[1];
        end
      end else begin
        shift_reg <= rx_byte;
        bit_reg   <= bit_reg + 4'h1;
      end
      if (bit_reg == tcp_pkg::BIT_LAST) begin
        unique case (state_reg)
          tcp_pkg::TCP_ADDR: begin
            if (rx_byte[7:1] == tcp_pkg::DEV_ADDR) begin
              ack_reg        <= 1'b1;
              master_nak_reg <= 1'b0;
              state_reg      <= rx_byte[0] ? tcp_pkg::TCP_RD
                                           : tcp_pkg::TCP_PTR;
            end else begin
              state_reg <= tcp_pkg::TCP_IDLE;
            end
          end
          tcp_pkg::TCP_PTR: begin
            ack_reg   <= 1'b1;
            state_reg <= tcp_pkg::TCP_WR;
          end
          tcp_pkg::TCP_WR: begin
            ack_reg <= wq_ready;
          end
          tcp_pkg::TCP_RD: begin
            ack_reg <= 1'b0;
          end
          default: begin
            state_reg <= tcp_pkg::TCP_IDLE;
          end
        endcase
      end
    end else if (scl_fall && bit_reg == 4'h0) begin
      ack_reg <= 1'b0;
      if (state_reg == tcp_pkg::TCP_RD && master_nak_reg) begin
        state_reg <= tcp_pkg::TCP_IDLE;
      end
    end
  end

  // pointer load and auto increment, no length limit
  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      ptr_reg <= tcp_pkg::PTR_RESET;
    end else if (scl_rise && bit_reg == tcp_pkg::BIT_LAST) begin
      if (state_reg == tcp_pkg::TCP_PTR) begin
        ptr_reg <= rx_byte;
      end else if (state_reg == tcp_pkg::TCP_WR && wq_ready) begin
        ptr_reg <= ptr_reg + 8'h01;
      end
    end else if (scl_fall && bit_reg == 4'h0 && !master_nak_reg &&
                 state_reg == tcp_pkg::TCP_RD) begin
      ptr_reg <= ptr_reg + 8'h01;
    end
  end

  // write byte enters the buffer at its eighth bit
  assign wq_valid = scl_rise && bit_reg == tcp_pkg::BIT_LAST &&
                    state_reg == tcp_pkg::TCP_WR && !start_det &&
                    !stop_det;
  assign wq_addr  = ptr_reg;
  assign wq_data  = rx_byte;

  tcp_buf2 u_buf (
    .sys_clk   (sys_clk),
    .nrst      (nrst),
    .in_valid  (wq_valid),
    .in_ready  (wq_ready),
    .in_addr   (wq_addr),
    .in_data   (wq_data),
    .out_valid (wb_valid),
    .out_ready (1'b1),
    .out_addr  (wb_addr),
    .out_data  (wb_data)
  );

  // general register map storage
  always_ff @(posedge sys_clk) begin
    if (wb_valid && wb_addr != tcp_pkg::CHG_CFG_OFFSET) begin
      regmap_reg[wb_addr] <= wb_data;
    end
  end

  // charge configuration register
  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      cfg_reg <= tcp_pkg::CHG_CFG_RESET;
    end else if (wb_valid && wb_addr == tcp_pkg::CHG_CFG_OFFSET) begin
      cfg_reg <= wb_data;
    end
  end

  // transmit byte loaded when a read byte begins
  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      tx_reg <= 8'h00;
    end else if (scl_fall && bit_reg == 4'h0 &&
                 state_reg == tcp_pkg::TCP_RD) begin
      tx_reg <= rd_data;
    end else if (scl_fall && bit_reg != 4'h0 &&
                 bit_reg != tcp_pkg::BIT_ACK) begin
      tx_reg <= {tx_reg[6:0], 1'b0};
    end
  end

  // data line drive, updated on clock low edges, released on start or stop
  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      drive_reg   <= 1'b0;
      drv_val_reg <= 1'b1;
    end else if (start_det || stop_det) begin
      drive_reg <= 1'b0;
    end else if (scl_fall) begin
      if (bit_reg == tcp_pkg::BIT_ACK) begin
        drive_reg   <= ack_reg;
        drv_val_reg <= 1'b0;
      end else if (state_reg == tcp_pkg::TCP_RD && bit_reg == 4'h0 &&
                   !master_nak_reg) begin
        drive_reg   <= ~rd_data[7];
        drv_val_reg <= 1'b0;
      end else if (state_reg == tcp_pkg::TCP_RD && bit_reg != 4'h0 &&
                   bit_reg != tcp_pkg::BIT_ACK) begin
        drive_reg   <= ~tx_reg[6];
        drv_val_reg <= 1'b0;
      end else begin
        drive_reg <= 1'b0;
      end
    end
  end

  assign sda_o  = drv_val_reg;
  assign sda_oe = drive_reg;
  assign busy   = (state_reg != tcp_pkg::TCP_IDLE);

  // charge path decode
  assign key  = cfg_reg[tcp_pkg::KEY_LSB +: 4];
  assign dsel = cfg_reg[tcp_pkg::DIODE_LSB +: 2];
  assign rsel = cfg_reg[tcp_pkg::RES_LSB +: 2];

  // registered charge path outputs
  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      charge_enable      <= 1'b0;
      charge_diode       <= 1'b0;
      charge_res_sel     <= 2'h0;
      charge_path_config <= tcp_pkg::CHG_CFG_RESET;
    end else begin
      charge_enable  <= (key == tcp_pkg::CHG_KEY) &&
                        (dsel == 2'h1 || dsel == 2'h2) &&
                        (rsel != 2'h0);
      charge_diode       <= (dsel == 2'h2);
      charge_res_sel     <= rsel;
      charge_path_config <= cfg_reg;
    end
  end
endmodule

// ===== tb/i2c_slave_register_port_bench.sv
// self-checking bench for the two-wire slave register port
`timescale 1ns/10ps
module i2c_slave_register_port_bench;
  logic       sys_clk = 1'b0;
  logic       nrst = 1'b0;
  logic       scl;
  logic       sda_pull;
  logic       sda_line;
  logic       sda_o;
  logic       sda_oe;
  logic       charge_enable;
  logic       charge_diode;
  logic [1:0] charge_res_sel;
  logic [7:0] charge_path_config;
  logic       busy;
  logic [7:0] q;
  logic       ack;
  int         bad_count = 0;
  int         checks_done = 0;
  logic [7:0] tbl [8] = '{8'hA5, 8'hA9, 8'hA6, 8'hAB,
                          8'hA0, 8'hAD, 8'hA4, 8'h55};
  always #2 sys_clk = ~sys_clk;
  // open-drain data wire with pull-up
  assign sda_line = ~((sda_oe & ~sda_o) | sda_pull);
  tcp_master_model m (.sys_clk(sys_clk), .sda_line(sda_line),
    .scl(scl), .sda_pull(sda_pull));
  tcp_slave dut (.sys_clk(sys_clk), .nrst(nrst), .scl_i(scl),
    .sda_i(sda_line), .sda_o(sda_o), .sda_oe(sda_oe),
    .charge_enable(charge_enable), .charge_diode(charge_diode),
    .charge_res_sel(charge_res_sel),
    .charge_path_config(charge_path_config), .busy(busy));
  // compare and count
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    checks_done++;
    if (seen !== exp) begin
      bad_count++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic summarize;
    $display("checks %0d errors %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  // expected charge outputs for a config value
  function automatic logic [7:0] dec(input logic [7:0] v);
    logic en;
    en = v[7:4] == 4'hA && ^v[3:2] && |v[1:0];
    return {4'h0, en, v[3:2] == 2'h2, v[1:0]};
  endfunction
  // byte out with expected acknowledge level
  task automatic wr(input logic [7:0] d, input logic ea);
    m.xfer(d, 1'b1, q, ack);
    chk({7'h00, ack}, {7'h00, ea});
  endtask
  task automatic addr(input logic [7:0] a, input logic ea);
    m.start();
    wr(a, ea);
  endtask
  task automatic rd(input logic nack, input logic [7:0] exp);
    m.xfer(8'hFF, nack, q, ack);
    chk(q, exp);
  endtask
  task automatic outs(input logic [7:0] v);
    chk(charge_path_config, v);
    chk({4'h0, charge_enable, charge_diode, charge_res_sel}, dec(v));
  endtask
  // run-away guard, about ten times the expected run
  initial begin
    #200000;
    bad_count++;
    summarize();
  end
  initial begin
    repeat (5) @(negedge sys_clk);
    nrst = 1'b1;
    repeat (8) @(negedge sys_clk);
    outs(8'h00);
    // eight field combinations through register 10h
    foreach (tbl[i]) begin
      addr(8'hD0, 1'b0);
      wr(8'h10, 1'b0);
      wr(tbl[i], 1'b0);
      if (i == 0) begin
        wr(8'h5A, 1'b0);
        wr(8'h3C, 1'b0);
      end
      m.stop();
      outs(tbl[i]);
    end
    // pointer write, repeated start, read on
    addr(8'hD0, 1'b0);
    wr(8'h10, 1'b0);
    addr(8'hD1, 1'b0);
    rd(1'b0, 8'h55);
    rd(1'b1, 8'h5A);
    m.stop();
    chk({7'h00, sda_line}, 8'h01);
    addr(8'hD1, 1'b0);
    rd(1'b1, 8'h3C);
    m.stop();
    // foreign address ignored until next start
    addr(8'hD2, 1'b1);
    wr(8'h10, 1'b1);
    wr(8'h00, 1'b1);
    m.stop();
    outs(8'h55);
    summarize();
  end
endmodule

// ===== tb/tcp_master_model.sv
// two-wire bus master model, clock and open-drain data
`timescale 1ns/10ps
module tcp_master_model (
  input  wire logic sys_clk,
  input  wire logic sda_line,
  output logic      scl,
  output logic      sda_pull
);
  // bus idle: clock high, data released
  initial begin
    scl = 1'b1;
    sda_pull = 1'b0;
  end
  // a quarter of the 64 ns link period
  task automatic q4;
    repeat (4) @(negedge sys_clk);
  endtask
  // data moves in low phase, sampled mid high phase
  task automatic bit_io(input logic b, output logic r);
    q4();
    sda_pull = ~b;
    q4();
    scl = 1'b1;
    q4();
    r = sda_line;
    q4();
    scl = 1'b0;
  endtask
  // start or repeated start: data falls, clock high
  task automatic start;
    q4();
    sda_pull = 1'b0;
    q4();
    scl = 1'b1;
    q4();
    sda_pull = 1'b1;
    q4();
    scl = 1'b0;
  endtask
  // stop: data rises, clock high
  task automatic stop;
    q4();
    sda_pull = 1'b1;
    q4();
    scl = 1'b1;
    q4();
    sda_pull = 1'b0;
    q4();
  endtask
  // byte msb first, then the acknowledge pulse
  task automatic xfer(input logic [7:0] d, input logic ao,
                      output logic [7:0] q, output logic ai);
    for (int i = 7; i >= 0; i--)
      bit_io(d[i], q[i]);
    bit_io(ao, ai);
  endtask
endmodule

// ===== tb/tcp_props.sv
// concurrent checks on the two-wire slave ports
`timescale 1ns/10ps
module tcp_props (
  input wire logic       sys_clk,
  input wire logic       nrst,
  input wire logic       scl_i,
  input wire logic       sda_i,
  input wire logic       sda_o,
  input wire logic       sda_oe,
  input wire logic       charge_enable,
  input wire logic       charge_diode,
  input wire logic [1:0] charge_res_sel,
  input wire logic [7:0] charge_path_config,
  input wire logic       busy
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!nrst);
  logic key_ok;
  logic dio_ok;
  logic res_ok;
  // field decode of the config register
  assign key_ok = charge_path_config[7:4] == tcp_pkg::CHG_KEY;
  assign dio_ok = ^charge_path_config[3:2];
  assign res_ok = |charge_path_config[1:0];
  a_cfg_reset: assert property (
    $rose(nrst) |-> charge_path_config == 8'h00 && !charge_enable)
    else $error("config not clear after reset");
  a_key_gate: assert property (
    $stable(charge_path_config) && !key_ok |-> !charge_enable)
    else $error("enabled with wrong key");
  a_diode_gate: assert property (
    $stable(charge_path_config) && !dio_ok |-> !charge_enable)
    else $error("enabled with bad diode bits");
  a_res_gate: assert property (
    $stable(charge_path_config) && !res_ok |-> !charge_enable)
    else $error("enabled without resistor");
  a_enable_set: assert property (
    $stable(charge_path_config) && key_ok && dio_ok && res_ok |->
      charge_enable && charge_diode == charge_path_config[3]
      && charge_res_sel == charge_path_config[1:0])
    else $error("charge decode wrong");
  a_start_seen: assert property (
    scl_i && $fell(sda_i) |-> ##[1:8] busy)
    else $error("start not taken");
  a_stop_seen: assert property (
    scl_i && $rose(sda_i) |-> ##[1:8] !busy)
    else $error("stop not taken");
  a_sda_stable: assert property (
    scl_i [*5] |-> $stable(sda_oe))
    else $error("data moved while clock high");
  a_drive_low: assert property (
    sda_oe |-> !sda_o) else $error("driven line not low");
  a_ack_hold: assert property (
    $rose(sda_oe) |-> sda_oe [*8]) else $error("drive too short");
  a_idle_quiet: assert property (
    !busy [*2] |-> !sda_oe) else $error("idle device drives data");
endmodule
bind tcp_slave tcp_props u_props (
  .sys_clk(sys_clk), .nrst(nrst), .scl_i(scl_i), .sda_i(sda_i),
  .sda_o(sda_o), .sda_oe(sda_oe), .charge_enable(charge_enable),
  .charge_diode(charge_diode), .charge_res_sel(charge_res_sel),
  .charge_path_config(charge_path_config), .busy(busy));
